/* verilog/btc_pkg.sv */
// Shared constants and types for the block transfer channel.
// Assumes a 16-bit word whose bit 0 is the most significant (sign) bit.
package btc_pkg;
  // ----------------------------------------------------------------
  // Word and counter geometry
  // ----------------------------------------------------------------
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 15;
  localparam int CNT_W     = 16;  // Wide enough to hold 32768
  localparam int UNIT_W    = 4;   // Up to 16 units per channel
  localparam int MAX_CHANS = 8;
  localparam logic [CNT_W-1:0] MAX_BLOCK = 16'h8000; // 32,768 words

  // Bit 0 (sign) is the MSB; bit 13 sits two places above the LSB
  localparam int TERM_POS  = WORD_W - 1 - 0;
  localparam int STORE_POS = WORD_W - 1 - 13;

  // ----------------------------------------------------------------
  // Dedicated memory locations (octal 1060 .. 1077)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LOC_BASE = 15'h0230; // Octal 1060
  localparam logic [ADDR_W-1:0] LOC_LAST = 15'h023F; // Octal 1077

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Memory cycle request towards the priority arbiter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH_ADDR, ST_FETCH_CNT, ST_READY, ST_XFER, ST_STORE
  } chan_state_t;
endpackage : btc_pkg

/* verilog/block_xfer_channel.sv */
// Block transfer channel: address and count counters, initialisation,
// cycle stealing for unit words, automatic re-initialisation.
// Assumes the arbiter pulses mem_avail for one cycle per granted
// request, with read data valid in that same cycle.
//
// Functional notes
// R1 - Address and count counters, full words
// R2 - Blocks up to 32,768 words each
// R3 - Up to 16 units, one selected
// R4 - Locations octal 1060 plus 2(n-1)
// R5 - Each word: address up, count down
// R6 - Sign bit of count sets terminate
// R7 - Initialise fetches address word first
// R8 - Count word fetched right after address
// R9 - Request cycle, connect unit, one word
// R10 - Unit starts every word transfer
// R11 - Unit raises initialise on command
// R12 - Zero count, no terminate: refetch
// R13 - Interrupt after automatic re-initialisation
// R14 - Terminate: interrupt, idle, ignore requests
// R15 - Command bit 13 stores address back
// R16 - Pending cycle first, then store back
// R17 - Unit holds maximum rate line (not modelled: the channel has no such input)
// R18 - Reset clears latch, pending, idles
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Word FIFO between the unit and the memory side
// ------------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      fill;
  logic             push;
  logic             pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];
  assign out_valid = (fill != '0);
  // Storage has no reset; only pointers, fill level and ready need a defined value
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and fill level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  // Registered ready leaves a spare slot, so full is never overrun
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (fill + (PW+1)'(push) - (PW+1)'(pop))
                  < (PW+1)'(DEPTH - 1);
    end
  end
endmodule : word_fifo

// ------------------------------------------------------------------
// Channel controller
// ------------------------------------------------------------------
module block_xfer_channel
  import btc_pkg::*;
#(
  parameter int CHAN_NUM = 1  // Channel 1..8
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Unit side
  input  wire logic              init_req,
  input  wire logic [UNIT_W-1:0] unit_sel,
  input  wire logic              cmd_strobe,
  input  wire logic [WORD_W-1:0] cmd_word,
  input  wire logic [WORD_W-1:0] unit_data,
  input  wire logic              unit_valid,
  output logic                   unit_ready,
  output logic                   unit_connect,
  output logic [UNIT_W-1:0]      selected_unit,
  output logic                   block_irq,
  output logic                   active,
  // Arbiter and memory side
  output mem_cmd_t               mem_cmd,
  input  wire logic              mem_avail,
  input  wire logic [WORD_W-1:0] mem_rdata
);
  // ----------------------------------------------------------------
  // Dedicated locations for this channel
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LOC_CWA =
    LOC_BASE + ADDR_W'(2 * (CHAN_NUM - 1));              // R4
  localparam logic [ADDR_W-1:0] LOC_CNT = LOC_CWA + 1'b1; // R4
  chan_state_t       state;
  chan_state_t       next_state;
  logic [ADDR_W-1:0] current_word_address;
  logic [CNT_W-1:0]  remaining_word_count;
  logic              term_latch;
  logic              store_pending;
  logic              reinit;
  logic [WORD_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_pop;
  logic              grant_xfer;
  logic              last_word;
  logic              store_cmd;
  assign grant_xfer = (state == ST_XFER) && mem_avail;
  assign fifo_pop   = grant_xfer;
  assign last_word  = (remaining_word_count == CNT_W'(1));
  assign store_cmd  = cmd_strobe && cmd_word[STORE_POS];  // R15
  // Back-pressure: the FIFO only drains on granted cycles
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_data   (unit_data),
    .in_valid  (unit_valid),
    .in_ready  (unit_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state; each memory state waits for its own grant
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (init_req) next_state = ST_FETCH_ADDR;          // R7
      end
      ST_FETCH_ADDR: begin
        if (mem_avail) next_state = ST_FETCH_CNT;          // R8
      end
      ST_FETCH_CNT: begin
        if (mem_avail) next_state = ST_READY;
      end
      ST_READY: begin
        if (init_req)           next_state = ST_FETCH_ADDR;
        else if (store_pending) next_state = ST_STORE;     // R15
        else if (fifo_valid)    next_state = ST_XFER;      // R9 R10
      end
      ST_XFER: begin
        if (mem_avail) begin
          if (last_word && term_latch) next_state = ST_IDLE; // R14
          else if (last_word)     next_state = ST_FETCH_ADDR; // R12
          else if (store_pending || store_cmd)
            next_state = ST_STORE;                         // R16
          else                    next_state = ST_READY;
        end
      end
      ST_STORE: begin
        if (mem_avail) next_state = ST_READY;
      end
      default: next_state = ST_IDLE;
    endcase
  end
  // State register; reset parks the channel idle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) state <= ST_IDLE;                         // R18
    else         state <= next_state;
  end
  // Address and count counters
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      current_word_address <= '0;
      remaining_word_count <= '0;
    end else if (state == ST_FETCH_ADDR && mem_avail) begin
      current_word_address <= mem_rdata[ADDR_W-1:0];        // R1 R7
    end else if (state == ST_FETCH_CNT && mem_avail) begin
      // A zero length field stands for the largest block
      remaining_word_count <= (mem_rdata[ADDR_W-1:0] == '0)
        ? MAX_BLOCK : CNT_W'(mem_rdata[ADDR_W-1:0]);        // R2 R8
    end else if (grant_xfer) begin
      current_word_address <= current_word_address + 1'b1;  // R5
      remaining_word_count <= remaining_word_count - 1'b1;  // R5
    end
  end
  // Terminate latch from the sign bit of the count word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      term_latch <= 1'b0;                                   // R18
    end else if (state == ST_FETCH_CNT && mem_avail) begin
      term_latch <= mem_rdata[TERM_POS];                    // R6
    end
  end
  // Re-initialisation marker, so the interrupt follows the refetch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reinit <= 1'b0;
    end else if (grant_xfer && last_word && !term_latch) begin
      reinit <= 1'b1;                                       // R12
    end else if (state == ST_FETCH_CNT && mem_avail) begin
      reinit <= 1'b0;
    end
  end
  // Store-back request; a new command beats the clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      store_pending <= 1'b0;                                // R18
    end else if (store_cmd && state != ST_IDLE) begin
      store_pending <= 1'b1;                                // R16
    end else if (state == ST_STORE && mem_avail) begin
      store_pending <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Memory command follows the state being entered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_cmd <= '0;
    end else begin
      mem_cmd <= '0;
      case (next_state)
        ST_FETCH_ADDR: begin
          mem_cmd.req  <= 1'b1;
          mem_cmd.addr <= LOC_CWA;                          // R7
        end
        ST_FETCH_CNT: begin
          mem_cmd.req  <= 1'b1;
          mem_cmd.addr <= LOC_CNT;                          // R8
        end
        ST_XFER: begin
          mem_cmd.req   <= 1'b1;                            // R9
          mem_cmd.write <= 1'b1;
          mem_cmd.addr  <= current_word_address;
          mem_cmd.wdata <= fifo_data;
        end
        ST_STORE: begin
          mem_cmd.req   <= 1'b1;
          mem_cmd.write <= 1'b1;
          mem_cmd.addr  <= LOC_CWA;                         // R15
          // Address after the word in flight has been counted
          mem_cmd.wdata <= WORD_W'(grant_xfer
            ? current_word_address + 1'b1 : current_word_address);
        end
        default: ;
      endcase
    end
  end
  // Unit selection is captured when a unit initialises
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      selected_unit <= '0;
    end else if (init_req && (state == ST_IDLE || state == ST_READY)) begin
      selected_unit <= unit_sel;                            // R3 R11
    end
  end
  // Connect strobe, interrupt pulse and activity level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      unit_connect <= 1'b0;
      block_irq    <= 1'b0;
      active       <= 1'b0;
    end else begin
      unit_connect <= grant_xfer;                           // R9
      block_irq    <= (grant_xfer && last_word && term_latch) // R14
                   || (state == ST_FETCH_CNT && mem_avail && reinit); // R13
      active       <= (next_state != ST_IDLE);
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_fetch_order: assert property (                          // R8
    state == ST_FETCH_ADDR && mem_avail |=> state == ST_FETCH_CNT)
    else $error("count fetch did not follow address fetch");
  a_init_addr: assert property (                            // R4 R7
    state == ST_FETCH_ADDR |-> mem_cmd.req && mem_cmd.addr == LOC_CWA)
    else $error("address fetch uses wrong location");
  a_cnt_addr: assert property (                             // R4
    state == ST_FETCH_CNT |-> mem_cmd.addr == LOC_CWA + 1'b1)
    else $error("count fetch uses wrong location");
  a_count_step: assert property (                           // R5
    grant_xfer |=> remaining_word_count ==
      $past(remaining_word_count) - 1'b1
      && current_word_address == $past(current_word_address) + 1'b1)
    else $error("counters did not step on a word");
  a_term_load: assert property (                            // R6
    state == ST_FETCH_CNT && mem_avail |=>
      term_latch == $past(mem_rdata[TERM_POS]))
    else $error("terminate latch not loaded from sign bit");
  a_term_stop: assert property (                            // R14
    grant_xfer && last_word && term_latch |=>
      state == ST_IDLE && block_irq ##1 !unit_connect)
    else $error("terminated block did not stop");
  a_auto_reinit: assert property (                          // R12 R13
    grant_xfer && last_word && !term_latch |=>
      state == ST_FETCH_ADDR && !block_irq)
    else $error("block end did not refetch");
  a_idle_quiet: assert property (                           // R14 R18
    state == ST_IDLE |-> !mem_cmd.req ##1 !unit_connect)
    else $error("idle channel requested memory");
  a_store_after: assert property (                          // R16
    state == ST_XFER && mem_avail && store_pending && !last_word
      |=> state == ST_STORE)
    else $error("store-back not done after pending cycle");
  a_connect_grant: assert property (                        // R9
    unit_connect |-> $past(grant_xfer))
    else $error("unit connected without a grant");
  a_count_max: assert property (remaining_word_count <= MAX_BLOCK) // R2
    else $error("word count above largest block");
  c_init: cover property (state == ST_FETCH_CNT && mem_avail);
  c_reinit_irq: cover property (block_irq && state == ST_READY);
  c_term: cover property (block_irq && state == ST_IDLE);
  c_store: cover property (state == ST_STORE && mem_avail);
  c_fifo_full: cover property (!unit_ready && unit_valid);
endmodule : block_xfer_channel

/* tb/mem_arbiter_model.sv */
// Stand-in for the priority arbiter and main memory of one channel.
// Assumes a single requester; the bench sets the grant delay.
`timescale 1ns/1ps
module mem_arbiter_model
  import btc_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  mem_cmd_t          mem_cmd,
  input  wire logic [2:0]   gnt_delay,
  output logic              mem_avail,
  output logic [WORD_W-1:0] mem_rdata
);
  // ----------------------------------------------------------------
  // Grant sequencing
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [2:0]        wait_cnt;

  // One-cycle grant after the delay; data lines toggle outside grants
  // so a late sample never sees a stale but plausible word
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_avail <= 1'b0;
      wait_cnt  <= 3'h0;
      mem_rdata <= 16'hA5C3;
    end else if (mem_avail) begin
      mem_avail <= 1'b0;
      wait_cnt  <= 3'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_cmd.req && mem_cmd.write) begin
        mem[mem_cmd.addr] <= mem_cmd.wdata;
      end
    end else if (mem_cmd.req && wait_cnt >= gnt_delay) begin
      mem_avail <= 1'b1;
      mem_rdata <= mem[mem_cmd.addr];
    end else begin
      wait_cnt  <= mem_cmd.req ? wait_cnt + 3'h1 : 3'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_arbiter_model

/* tb/block_xfer_channel_tb.sv */
// Self-checking bench for the block transfer channel.
// Assumes the memory model answers every cycle request.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module block_xfer_channel_tb
  import btc_pkg::*;
;
  localparam int CH = 5;
  localparam logic [ADDR_W-1:0] LOC_A = LOC_BASE + 15'(2 * (CH - 1));
  logic              core_clk   = 1'b0;
  logic              arst_n     = 1'b0;
  logic              init_req   = 1'b0;
  logic [UNIT_W-1:0] unit_sel   = '0;
  logic              cmd_strobe = 1'b0;
  logic [WORD_W-1:0] cmd_word   = '0;
  logic [WORD_W-1:0] unit_data  = '0;
  logic              unit_valid = 1'b0;
  logic [2:0]        gnt_delay  = 3'h0;
  logic              unit_ready, unit_connect, block_irq, active, mem_avail;
  logic [UNIT_W-1:0] selected_unit;
  logic [WORD_W-1:0] mem_rdata;
  mem_cmd_t          mem_cmd;
  logic [31:0]       exp_q[$];
  logic [31:0]       got, want;
  logic [ADDR_W-1:0] tb_cwa;
  logic [CNT_W-1:0]  tb_left;
  logic              tb_term, refused;
  int mismatches, samples_checked, irq_seen, conn_seen, exp_irq, exp_conn;

  always #2 core_clk = ~core_clk;

  block_xfer_channel #(.CHAN_NUM(CH)) u_block_xfer_channel (.core_clk,
    .arst_n, .init_req, .unit_sel, .cmd_strobe, .cmd_word, .unit_data,
    .unit_valid, .unit_ready, .unit_connect, .selected_unit, .block_irq,
    .active, .mem_cmd, .mem_avail, .mem_rdata);
  mem_arbiter_model u_mem_arbiter_model (.core_clk, .arst_n, .mem_cmd,
    .gnt_delay, .mem_avail, .mem_rdata);

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  // Each granted cycle takes the oldest expected access off the queue
  always @(posedge core_clk) begin
    if (arst_n && mem_cmd.req && mem_avail) begin
      got  = {mem_cmd.write, mem_cmd.addr,
              mem_cmd.write ? mem_cmd.wdata : 16'h0000};
      want = (exp_q.size() != 0) ? exp_q.pop_front() : 32'hx;
      `CHK(got, want)
    end
    if (block_irq) irq_seen++;
    if (unit_connect) conn_seen++;
  end

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic setup_block(input logic t, input logic [14:0] n);
    u_mem_arbiter_model.mem[LOC_A] = 16'h4000 | 16'($urandom);
    u_mem_arbiter_model.mem[LOC_A + 15'h1] = {t, n};
  endtask : setup_block

  // Both fetches go first; counters mirror the words just stored
  task automatic expect_fetch;
    logic [WORD_W-1:0] cw;
    cw = u_mem_arbiter_model.mem[LOC_A + 15'h1];
    exp_q.push_back({1'b0, LOC_A, 16'h0000});
    exp_q.push_back({1'b0, LOC_A + 15'h1, 16'h0000});
    tb_cwa  = u_mem_arbiter_model.mem[LOC_A][ADDR_W-1:0];
    tb_term = cw[TERM_POS];
    tb_left = {cw[14:0] == 15'h0, cw[14:0]};
  endtask : expect_fetch

  task automatic settle;
    int i;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge core_clk);
    if (i == 3000) begin
      mismatches++;
      stop_test();
    end
    repeat (3) @(negedge core_clk);
  endtask : settle

  task automatic start;
    logic [UNIT_W-1:0] u;
    u = 4'($urandom);
    expect_fetch();
    init_req = 1'b1;
    unit_sel = u;
    @(negedge core_clk);
    init_req = 1'b0;
    settle();
    `CHK(selected_unit, u)
  endtask : start

  // Unit offers each word only while the buffer can take it
  task automatic push(input int n);
    int i, k;
    for (i = 0; i < n; i++) begin
      for (k = 0; k < 500 && unit_ready !== 1'b1; k++) begin
        refused = 1'b1;
        @(negedge core_clk);
      end
      if (k == 500) begin
        mismatches++;
        stop_test();
      end
      unit_data  = 16'($urandom);
      unit_valid = 1'b1;
      exp_q.push_back({1'b1, tb_cwa, unit_data});
      exp_conn++;
      tb_cwa++;
      tb_left--;
      if (tb_left == 16'h0) begin
        exp_irq++;
        if (!tb_term) expect_fetch();
      end
      @(negedge core_clk);
    end
    unit_valid = 1'b0;
  endtask : push

  task automatic strobe(input logic [WORD_W-1:0] w);
    cmd_strobe = 1'b1;
    cmd_word   = w;
    @(negedge core_clk);
    cmd_strobe = 1'b0;
  endtask : strobe

  task automatic end_test(input string name);
    settle();
    `CHK(irq_seen, exp_irq)
    `CHK(conn_seen, exp_conn)
    `CHK(active, 1'b0)
    $display("test %s done", name);
  endtask : end_test

  initial begin
    void'($urandom(32'h8E6C1C00));
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    `CHK({unit_ready, active, block_irq, mem_cmd.req}, 4'b1000)
    end_test("reset");
    // Single-word block with terminate set
    setup_block(1'b1, 15'h0001);
    start();
    push(1);
    end_test("terminate");
    // Two blocks chained by automatic refetch, slow grants
    setup_block(1'b0, 15'h0002);
    start();
    setup_block(1'b1, 15'h0003);
    gnt_delay = 3'h2;
    push(5);
    end_test("reinit");
    // Store-back while a word cycle is still waiting for its grant
    setup_block(1'b1, 15'h0003);
    start();
    gnt_delay = 3'h4;
    push(1);
    @(negedge core_clk);
    strobe(16'h1 << STORE_POS);
    exp_q.push_back({1'b1, LOC_A, 1'b0, tb_cwa});
    settle();
    strobe(~(16'h1 << STORE_POS));
    gnt_delay = 3'h0;
    push(2);
    end_test("store");
    // Very slow grants fill the buffer until it refuses
    refused = 1'b0;
    setup_block(1'b1, 15'h0014);
    start();
    gnt_delay = 3'h7;
    push(20);
    `CHK(refused, 1'b1)
    end_test("fifo full");
    // Largest block, then a reset while a word waits for its grant
    setup_block(1'b1, 15'h0000);
    start();
    push(1);
    settle();
    push(1);
    repeat (2) @(negedge core_clk);
    arst_n = 1'b0;
    exp_q.delete();
    exp_conn--;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    `CHK({unit_ready, active, block_irq, mem_cmd.req}, 4'b1000)
    end_test("reset mid-block");
    // With the channel idle after the reset, a unit request starts no memory cycle
    unit_valid = 1'b1;
    unit_data  = 16'h5A5A;
    @(negedge core_clk);
    unit_valid = 1'b0;
    repeat (30) @(negedge core_clk);
    `CHK(mem_cmd.req, 1'b0)
    $display("test ignore done");
    stop_test();
  end
endmodule : block_xfer_channel_tb
